// ===== rtl/eatx_consts.vh
// Constants for the explicit-address transmit request frame parser
`ifndef EATX_CONSTS_VH
`define EATX_CONSTS_VH

`define EATX_START_DELIM      8'h7E
`define EATX_TYPE_EXPLICIT    8'h11
`define EATX_TYPE_TX_STATUS   8'h8B
`define EATX_CKSUM_BASE       8'hFF

`define EATX_OFF_TYPE         16'h0003
`define EATX_OFF_TAG          16'h0004
`define EATX_OFF_DEST64       16'h0005
`define EATX_OFF_DEST16       16'h000D
`define EATX_OFF_SRC_EP       16'h000F
`define EATX_OFF_DST_EP       16'h0010
`define EATX_OFF_CLUSTER      16'h0011
`define EATX_OFF_PROFILE      16'h0013
`define EATX_OFF_RADIUS       16'h0015
`define EATX_OFF_OPTIONS      16'h0016
`define EATX_OFF_PAYLOAD      16'h0017
`define EATX_HDR_LEN          16'h0014

`define EATX_NET16_RESERVED   16'hFFFE
`define EATX_BCAST64          64'h000000000000FFFF
`define EATX_EP_DATA          8'hE8
`define EATX_EP_DEVOBJ        8'hE6
`define EATX_EP_SS_SERVER     8'hE5
`define EATX_EP_SS_CLIENT     8'hE4
`define EATX_EP_SS_AUTH       8'hE3
`define EATX_EP_RSV_LO        8'hDC
`define EATX_EP_RSV_HI        8'hEE
`define EATX_CL_TRANSPARENT   16'h0011
`define EATX_CL_LOOPBACK      16'h0012
`define EATX_PROF_NATIVE      16'hC105
`define EATX_PROF_DEVICE      16'h0000

`define EATX_OPT_NO_ACK       0
`define EATX_OPT_NO_ROUTE     1
`define EATX_OPT_METHOD_LO    6
`define EATX_OPT_METHOD_HI    7
`define EATX_OPT_USED_MASK    8'hDF
`define EATX_METHOD_INVALID   2'h0

`define EATX_BUF_DEPTH        2
`endif

// ===== rtl/eatx_frame_parser.v
// Parser and checker for the explicit-address transmit request frame
`timescale 1ns/1ps
`include "eatx_consts.vh"

// Summary of operation
// - Frame starts with 0x7E delimiter
// - Big-endian length counts bytes between length and checksum
// - Type byte 0x11 selects this request
// - Zero correlation tag suppresses status answer
// - Nonzero tag yields 0x8B status, same tag
// - Short address is reserved, ignored
// - Recognise active reserved endpoints
// - Cluster at 17-18, 0x0011 transparent data
// - Cluster 0x0012 on data endpoint loops back
// - Profile at 19-20, serial uses 0xC105
// - Profiles 0xC105, 0x0000 internal, others forwarded
// - Zero hop radius takes default limit
// - Zero options take default options
// - Bit0 no ack, bit1 no route
// - Bits 7:6 delivery method, 00 invalid
// - Payload from 23, capped by maximum
// - Checksum is 0xFF minus byte sum
module eatx_frame_parser (
  input  wire        core_clk_i,
  input  wire        rst_i,
  input  wire [7:0]  rx_byte_i,
  input  wire        rx_valid_i,
  output reg         rx_ready_o,
  input  wire [15:0] max_payload_setting_i,
  input  wire [7:0]  default_hop_limit_i,
  input  wire [7:0]  default_tx_options_i,
  output reg  [7:0]  pl_data_o,
  output reg         pl_last_o,
  output reg         pl_valid_o,
  input  wire        pl_ready_i,
  output reg         frame_ok_o,
  output reg         frame_bad_o,
  output reg         status_req_o,
  output reg  [7:0]  status_type_o,
  output reg  [7:0]  status_tag_o,
  output reg  [63:0] dest64_o,
  output reg         bcast_o,
  output reg  [7:0]  src_ep_o,
  output reg  [7:0]  dst_ep_o,
  output reg  [2:0]  ep_class_o,
  output reg  [15:0] cluster_o,
  output reg  [15:0] profile_o,
  output reg         loopback_o,
  output reg         forward_host_o,
  output reg  [7:0]  hop_limit_o,
  output reg  [7:0]  tx_options_o,
  output reg         no_ack_o,
  output reg         no_route_o,
  output reg  [1:0]  method_o,
  output reg         opt_bad_o
);
  localparam [4:0] ST_HUNT = 5'h01;
  localparam [4:0] ST_LENH = 5'h02;
  localparam [4:0] ST_LENL = 5'h04;
  localparam [4:0] ST_BODY = 5'h08;
  localparam [4:0] ST_SUM  = 5'h10;

  reg  [4:0]  state_reg;
  reg  [4:0]  state_next;
  reg  [15:0] len_reg;
  reg  [15:0] off_reg;
  reg  [7:0]  sum_reg;
  reg  [7:0]  type_reg;
  reg  [7:0]  tag_reg;
  reg  [63:0] d64_reg;
  reg  [7:0]  sep_reg;
  reg  [7:0]  dep_reg;
  reg  [15:0] clu_reg;
  reg  [15:0] pro_reg;
  reg  [7:0]  rad_reg;
  reg  [7:0]  opt_reg;
  wire        take;
  wire [7:0]  sum_new;
  wire        body_end;
  wire        in_payload;
  wire [15:0] pl_count;
  wire [8:0]  buf_out;
  wire        buf_valid;
  wire        buf_in_ready;
  wire        buf_push;
  wire        len_ok;
  wire        sum_ok;
  wire [7:0]  eff_opt;

  // Classify endpoint: 1 data, 2 dev object, 3-5 secure, 6 other reserved, 0 user
  function [2:0] ep_class;
    input [7:0] ep;
    begin
      if (ep == `EATX_EP_DATA)
        ep_class = 3'h1;
      else if (ep == `EATX_EP_DEVOBJ)
        ep_class = 3'h2;
      else if (ep == `EATX_EP_SS_SERVER)
        ep_class = 3'h3;
      else if (ep == `EATX_EP_SS_CLIENT)
        ep_class = 3'h4;
      else if (ep == `EATX_EP_SS_AUTH)
        ep_class = 3'h5;
      else if (ep >= `EATX_EP_RSV_LO && ep <= `EATX_EP_RSV_HI)
        ep_class = 3'h6;
      else
        ep_class = 3'h0;
    end
  endfunction

  // Payload stalls the stream while the buffer is full and for one cycle after each buffered byte
  assign in_payload = (state_reg == ST_BODY) && (off_reg >= `EATX_OFF_PAYLOAD);
  assign take       = rx_valid_i & rx_ready_o;
  assign sum_new    = sum_reg + rx_byte_i;
  // body spans length bytes from offset 3
  assign body_end   = (off_reg == len_reg + `EATX_OFF_TAG - 16'h0002);
  assign pl_count   = off_reg - `EATX_OFF_PAYLOAD;
  // payload cap, overflow bytes are dropped
  assign buf_push   = take && in_payload && (type_reg == `EATX_TYPE_EXPLICIT)
                      && (pl_count < max_payload_setting_i);
  assign len_ok     = (len_reg >= `EATX_HDR_LEN);
  // sum of body plus checksum must be 0xFF
  assign sum_ok     = (sum_new == `EATX_CKSUM_BASE);
  assign eff_opt    = (opt_reg == 8'h00) ? default_tx_options_i : opt_reg;

  // State sequencing
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_HUNT: begin
        if (take && rx_byte_i == `EATX_START_DELIM)
          state_next = ST_LENH;
      end
      ST_LENH: begin
        if (take)
          state_next = ST_LENL;
      end
      ST_LENL: begin
        if (take)
          state_next = (rx_byte_i == 8'h00 && len_reg[15:8] == 8'h00) ? ST_SUM : ST_BODY;
      end
      ST_BODY: begin
        if (take && body_end)
          state_next = ST_SUM;
      end
      ST_SUM: begin
        if (take)
          state_next = ST_HUNT;
      end
      default: state_next = ST_HUNT;
    endcase
  end

  // Byte ready: hold off while payload buffer is full
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i)
      rx_ready_o <= 1'b0;
    else
      rx_ready_o <= buf_in_ready & ~(take & in_payload & buf_push);
  end

  // Frame capture registers
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_HUNT;
      len_reg   <= 16'h0000;
      off_reg   <= 16'h0000;
      sum_reg   <= 8'h00;
      type_reg  <= 8'h00;
      tag_reg   <= 8'h00;
      d64_reg   <= 64'h0000000000000000;
      sep_reg   <= 8'h00;
      dep_reg   <= 8'h00;
      clu_reg   <= 16'h0000;
      pro_reg   <= 16'h0000;
      rad_reg   <= 8'h00;
      opt_reg   <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (take) begin
        case (state_reg)
          ST_HUNT: begin
            sum_reg <= 8'h00;
            off_reg <= `EATX_OFF_TYPE;
          end
          ST_LENH: len_reg[15:8] <= rx_byte_i;
          ST_LENL: len_reg[7:0]  <= rx_byte_i;
          ST_BODY: begin
            sum_reg <= sum_new;
            off_reg <= off_reg + 16'h0001;
            if (off_reg == `EATX_OFF_TYPE)
              type_reg <= rx_byte_i;
            if (off_reg == `EATX_OFF_TAG)
              tag_reg <= rx_byte_i;
            if (off_reg >= `EATX_OFF_DEST64 && off_reg < `EATX_OFF_DEST16)
              d64_reg <= {d64_reg[55:0], rx_byte_i};
            if (off_reg == `EATX_OFF_SRC_EP)
              sep_reg <= rx_byte_i;
            if (off_reg == `EATX_OFF_DST_EP)
              dep_reg <= rx_byte_i;
            if (off_reg == `EATX_OFF_CLUSTER || off_reg == `EATX_OFF_CLUSTER + 16'h0001)
              clu_reg <= {clu_reg[7:0], rx_byte_i};
            if (off_reg == `EATX_OFF_PROFILE || off_reg == `EATX_OFF_PROFILE + 16'h0001)
              pro_reg <= {pro_reg[7:0], rx_byte_i};
            if (off_reg == `EATX_OFF_RADIUS)
              rad_reg <= rx_byte_i;
            if (off_reg == `EATX_OFF_OPTIONS)
              opt_reg <= rx_byte_i;
          end
          default: sum_reg <= sum_reg;
        endcase
      end
    end
  end

  // Verdict and decoded fields, published at the checksum byte
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_ok_o     <= 1'b0;
      frame_bad_o    <= 1'b0;
      status_req_o   <= 1'b0;
      status_type_o  <= 8'h00;
      status_tag_o   <= 8'h00;
      dest64_o       <= 64'h0000000000000000;
      bcast_o        <= 1'b0;
      src_ep_o       <= 8'h00;
      dst_ep_o       <= 8'h00;
      ep_class_o     <= 3'h0;
      cluster_o      <= 16'h0000;
      profile_o      <= 16'h0000;
      loopback_o     <= 1'b0;
      forward_host_o <= 1'b0;
      hop_limit_o    <= 8'h00;
      tx_options_o   <= 8'h00;
      no_ack_o       <= 1'b0;
      no_route_o     <= 1'b0;
      method_o       <= 2'h0;
      opt_bad_o      <= 1'b0;
    end else begin
      frame_ok_o   <= 1'b0;
      frame_bad_o  <= 1'b0;
      status_req_o <= 1'b0;
      if (take && state_reg == ST_SUM) begin
        // bad sum, short length or wrong type drops the frame
        if (!sum_ok || !len_ok || type_reg != `EATX_TYPE_EXPLICIT) begin
          frame_bad_o <= 1'b1;
        end else begin
          frame_ok_o     <= 1'b1;
          status_req_o   <= (tag_reg != 8'h00);
          status_type_o  <= `EATX_TYPE_TX_STATUS;
          status_tag_o   <= tag_reg;
          dest64_o       <= d64_reg;
          bcast_o        <= (d64_reg == `EATX_BCAST64);
          src_ep_o       <= sep_reg;
          dst_ep_o       <= dep_reg;
          ep_class_o     <= ep_class(dep_reg);
          cluster_o      <= clu_reg;
          profile_o      <= pro_reg;
          loopback_o     <= (dep_reg == `EATX_EP_DATA) && (clu_reg == `EATX_CL_LOOPBACK);
          forward_host_o <= (pro_reg != `EATX_PROF_NATIVE) && (pro_reg != `EATX_PROF_DEVICE);
          hop_limit_o    <= (rad_reg == 8'h00) ? default_hop_limit_i : rad_reg;
          tx_options_o   <= eff_opt;
          no_ack_o       <= eff_opt[`EATX_OPT_NO_ACK];
          no_route_o     <= eff_opt[`EATX_OPT_NO_ROUTE];
          method_o       <= eff_opt[`EATX_OPT_METHOD_HI:`EATX_OPT_METHOD_LO];
          opt_bad_o      <= (eff_opt[`EATX_OPT_METHOD_HI:`EATX_OPT_METHOD_LO] == `EATX_METHOD_INVALID)
                            || ((eff_opt & ~`EATX_OPT_USED_MASK) != 8'h00);
        end
      end
    end
  end

  // Payload buffer, last flag marks final kept byte
  eatx_skid_buf u_buf (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .in_data_i   ({(body_end || pl_count + 16'h0001 == max_payload_setting_i), rx_byte_i}),
    .in_valid_i  (buf_push),
    .in_ready_o  (buf_in_ready),
    .out_data_o  (buf_out),
    .out_valid_o (buf_valid),
    .out_ready_i (~pl_valid_o | pl_ready_i)
  );

  // Output stage register keeps outputs flop-driven
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pl_valid_o <= 1'b0;
      pl_data_o  <= 8'h00;
      pl_last_o  <= 1'b0;
    end else if (~pl_valid_o | pl_ready_i) begin
      pl_valid_o <= buf_valid;
      pl_data_o  <= buf_out[7:0];
      pl_last_o  <= buf_out[8];
    end
  end
endmodule // eatx_frame_parser

// ===== rtl/eatx_skid_buf.v
// Two-entry valid/ready buffer for payload bytes
`timescale 1ns/1ps
module eatx_skid_buf (
  input  wire       core_clk_i,
  input  wire       rst_i,
  input  wire [8:0] in_data_i,
  input  wire       in_valid_i,
  output wire       in_ready_o,
  output wire [8:0] out_data_o,
  output wire       out_valid_o,
  input  wire       out_ready_i
);
  reg [8:0] mem_reg [0:1];
  reg       wr_ptr_reg;
  reg       rd_ptr_reg;
  reg [1:0] count_reg;
  wire      push;
  wire      pop;

  // Honest flags straight from the occupancy count
  assign in_ready_o  = (count_reg != 2'h2);
  assign out_valid_o = (count_reg != 2'h0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointer and count update
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push & ~pop)
        count_reg <= count_reg + 2'h1;
      else if (pop & ~push)
        count_reg <= count_reg - 2'h1;
    end
  end

  // Storage, no reset needed on data
  always @(posedge core_clk_i) begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data_i;
  end
endmodule // eatx_skid_buf

// ===== tb/eatx_host_model.sv
// Host-side source that builds request frames and offers their bytes
`timescale 1ns/1ps
module eatx_host_model (
  input  wire       core_clk_i,
  input  wire       rx_ready_o,
  output reg  [7:0] rx_byte_i,
  output reg        rx_valid_i
);
  int stuck;
  initial begin
    rx_byte_i = 8'h00;
    rx_valid_i = 1'b0;
  end
  // Offer one byte and hold it until taken; valid stays up between bytes
  task automatic offer(input logic [7:0] b);
    int n;
    rx_byte_i <= b;
    rx_valid_i <= 1'b1;
    n = 0;
    @(posedge core_clk_i);
    while (rx_ready_o !== 1'b1 && n < 300) begin
      @(posedge core_clk_i);
      n++;
    end
    // Counted so the bench can flag a wedged link
    if (rx_ready_o !== 1'b1)
      stuck++;
  endtask
  // Release; inverted byte so a stale value never looks valid
  task automatic idle;
    rx_valid_i <= 1'b0;
    rx_byte_i <= ~rx_byte_i;
  endtask
  task automatic send_frame(input logic [7:0] ty, tg, input logic [63:0] d64, input logic [7:0] ep,
                            input logic [15:0] cl, pr, input logic [7:0] rad, opt, pn, cor);
    logic [7:0]   body [$];
    logic [159:0] hdr;
    logic [7:0]   sum;
    logic [15:0]  len;
    hdr = {ty, tg, d64, 16'hFFFE, ep, ep, cl, pr, rad, opt};
    for (int i = 19; i >= 0; i--) body.push_back(hdr[i*8 +: 8]);
    for (int i = 0; i < pn; i++) body.push_back(8'h30 + i[7:0]);
    sum = 8'h00;
    foreach (body[i]) sum = sum + body[i];
    len = body.size();
    offer(8'h7E);
    offer(len[15:8]);
    offer(len[7:0]);
    foreach (body[i]) offer(body[i]);
    offer((8'hFF - sum) ^ cor);
    idle();
  endtask
endmodule // eatx_host_model

// ===== tb/eatx_properties.sv
// Concurrent checks on the frame parser ports
`timescale 1ns/1ps
module eatx_properties (
  input wire        core_clk_i,
  input wire        rst_i,
  input wire        rx_valid_i,
  input wire        rx_ready_o,
  input wire [7:0]  pl_data_o,
  input wire        pl_valid_o,
  input wire        pl_ready_i,
  input wire        frame_ok_o,
  input wire        frame_bad_o,
  input wire        status_req_o,
  input wire [7:0]  status_type_o,
  input wire [7:0]  status_tag_o,
  input wire [7:0]  dst_ep_o,
  input wire [15:0] cluster_o,
  input wire [15:0] profile_o,
  input wire        loopback_o,
  input wire        forward_host_o,
  input wire [7:0]  tx_options_o,
  input wire        no_ack_o,
  input wire        no_route_o,
  input wire [1:0]  method_o,
  input wire        opt_bad_o
);
  reg took_reg;
  // One clock, one reset for every check
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  // Remembers a byte handshake one cycle back
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) took_reg <= 1'b0;
    else took_reg <= rx_valid_i && rx_ready_o;
  end
  verdict_excl_a: assert property (!(frame_ok_o && frame_bad_o))
    else $error("good and bad verdict together");
  ok_after_take_a: assert property (frame_ok_o |-> took_reg)
    else $error("good verdict without a checksum byte taken");
  status_tag_a: assert property (status_req_o |-> frame_ok_o && status_tag_o != 8'h00)
    else $error("status request without good frame or with zero tag");
  status_type_a: assert property (status_req_o |-> status_type_o == 8'h8B)
    else $error("status request with wrong frame type");
  ok_spacing_a: assert property (frame_ok_o |=> !frame_ok_o [*8])
    else $error("good verdicts closer than a minimum frame");
  opt_split_a: assert property (frame_ok_o |->
    {method_o, no_route_o, no_ack_o} == {tx_options_o[7:6], tx_options_o[1:0]})
    else $error("option flags disagree with options byte");
  opt_bad_a: assert property (frame_ok_o |->
    opt_bad_o == (tx_options_o[7:6] == 2'b00 || tx_options_o[5]))
    else $error("option fault flag wrong");
  loopback_flag_a: assert property (frame_ok_o |->
    loopback_o == (dst_ep_o == 8'hE8 && cluster_o == 16'h0012))
    else $error("loopback flag wrong");
  forward_flag_a: assert property (frame_ok_o |->
    forward_host_o == (profile_o != 16'hC105 && profile_o != 16'h0000))
    else $error("forward flag wrong");
  pl_hold_a: assert property (pl_valid_o && !pl_ready_i |=> pl_valid_o && $stable(pl_data_o))
    else $error("payload dropped or changed while stalled");
  fields_hold_a: assert property (!frame_ok_o |-> $stable(cluster_o) && $stable(profile_o))
    else $error("decoded fields changed without a good frame");
endmodule // eatx_properties

bind eatx_frame_parser eatx_properties u_props (.core_clk_i, .rst_i, .rx_valid_i, .rx_ready_o,
  .pl_data_o, .pl_valid_o, .pl_ready_i, .frame_ok_o, .frame_bad_o, .status_req_o, .status_type_o,
  .status_tag_o, .dst_ep_o, .cluster_o, .profile_o, .loopback_o, .forward_host_o, .tx_options_o,
  .no_ack_o, .no_route_o, .method_o, .opt_bad_o);

// ===== tb/tb_eatx_frame_parser.sv
// Self-checking bench for the request frame parser
`timescale 1ns/1ps
module tb_eatx_frame_parser;
  logic        core_clk_i, rst_i, rx_valid_i, rx_ready_o, pl_ready_i, pl_last_o, pl_valid_o;
  logic        frame_ok_o, frame_bad_o, status_req_o, bcast_o, loopback_o, forward_host_o;
  logic        no_ack_o, no_route_o, opt_bad_o, hold_sink, last_seen;
  logic [7:0]  rx_byte_i, default_hop_limit_i, default_tx_options_i, pl_data_o, status_type_o;
  logic [7:0]  status_tag_o, src_ep_o, dst_ep_o, hop_limit_o, tx_options_o;
  logic [15:0] max_payload_setting_i, cluster_o, profile_o;
  logic [63:0] dest64_o;
  logic [2:0]  ep_class_o;
  logic [1:0]  method_o;
  logic [7:0]  pl_q [$];
  int          num_errors, samples_checked, n_ok, n_bad, n_st, cyc;

  eatx_frame_parser uut (.core_clk_i, .rst_i, .rx_byte_i, .rx_valid_i, .rx_ready_o,
    .max_payload_setting_i, .default_hop_limit_i, .default_tx_options_i, .pl_data_o, .pl_last_o,
    .pl_valid_o, .pl_ready_i, .frame_ok_o, .frame_bad_o, .status_req_o, .status_type_o,
    .status_tag_o, .dest64_o, .bcast_o, .src_ep_o, .dst_ep_o, .ep_class_o, .cluster_o, .profile_o,
    .loopback_o, .forward_host_o, .hop_limit_o, .tx_options_o, .no_ack_o, .no_route_o, .method_o,
    .opt_bad_o);
  eatx_host_model host (.core_clk_i, .rx_ready_o, .rx_byte_i, .rx_valid_i);

  // Clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // Sink stalls one cycle in three, or fully while held; counts verdicts
  always @(posedge core_clk_i) begin
    cyc++;
    pl_ready_i <= !hold_sink && (cyc % 3 != 0);
    if (pl_valid_o === 1'b1 && pl_ready_i === 1'b1) begin
      pl_q.push_back(pl_data_o);
      last_seen = pl_last_o;
    end
    if (frame_ok_o === 1'b1) n_ok++;
    if (frame_bad_o === 1'b1) n_bad++;
    if (status_req_o === 1'b1) n_st++;
  end

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  // Bounded wait for a verdict, then for the payload to drain
  task automatic wait_done(input int k0, b0);
    int n;
    n = 0;
    while (n_ok == k0 && n_bad == b0 && n < 300) begin
      @(posedge core_clk_i);
      n++;
    end
    chk("verdict_seen", 1, (n_ok != k0) || (n_bad != b0));
    chk("host_stuck", 0, host.stuck);
    n = 0;
    while (pl_valid_o !== 1'b0 && n < 50) begin
      @(posedge core_clk_i);
      n++;
    end
    chk("pl_drained", 0, pl_valid_o);
    @(posedge core_clk_i);
  endtask

  task automatic t_unicast_stall;
    int k0, s0;
    k0 = n_ok;
    s0 = n_st;
    pl_q = {};
    hold_sink <= 1'b1;
    fork
      host.send_frame(8'h11, 8'h87, 64'h0013A20012345678, 8'hE8, 16'h0011, 16'hC105, 8'h00, 8'h00, 6, 0);
      begin
        repeat (45) @(posedge core_clk_i);
        chk("rx_ready_full", 0, rx_ready_o);
        hold_sink <= 1'b0;
      end
    join
    wait_done(k0, n_bad);
    chk("ok_count", k0 + 1, n_ok);
    chk("status_count", s0 + 1, n_st);
    chk("status_tag", 8'h87, status_tag_o);
    chk("status_type", 8'h8B, status_type_o);
    chk("dest64", 64'h0013A20012345678, dest64_o);
    chk("src_ep", 8'hE8, src_ep_o);
    chk("dst_ep", 8'hE8, dst_ep_o);
    chk("profile", 16'hC105, profile_o);
    chk("ep_class", 1, ep_class_o);
    chk("hop", 8'h07, hop_limit_o);
    chk("options", 8'hC0, tx_options_o);
    chk("pl_count", 6, pl_q.size());
    foreach (pl_q[i]) chk("payload", 8'h30 + i, pl_q[i]);
  endtask

  task automatic t_loopback;
    int k0, s0;
    k0 = n_ok;
    s0 = n_st;
    host.send_frame(8'h11, 8'h00, 64'h0013A20012345678, 8'hE8, 16'h0012, 16'hC105, 8'h00, 8'h01, 2, 0);
    wait_done(k0, n_bad);
    chk("status_count", s0, n_st);
    chk("loopback", 1, loopback_o);
    chk("no_ack", 1, no_ack_o);
    chk("opt_bad", 1, opt_bad_o);
  endtask

  task automatic t_bcast_cap;
    int k0;
    k0 = n_ok;
    pl_q = {};
    max_payload_setting_i <= 16'h0003;
    host.send_frame(8'h11, 8'h21, 64'h000000000000FFFF, 8'hE6, 16'h0011, 16'h0104, 8'h05, 8'h82, 5, 0);
    wait_done(k0, n_bad);
    chk("bcast", 1, bcast_o);
    chk("ep_class", 2, ep_class_o);
    chk("forward", 1, forward_host_o);
    chk("hop", 8'h05, hop_limit_o);
    chk("no_route", 1, no_route_o);
    chk("method", 2, method_o);
    chk("pl_count", 3, pl_q.size());
    chk("pl_last", 1, last_seen);
    foreach (pl_q[i]) chk("payload", 8'h30 + i, pl_q[i]);
    max_payload_setting_i <= 16'h0010;
  endtask

  task automatic t_endpoints;
    logic [7:0] eps [5] = '{8'hE5, 8'hE4, 8'hE3, 8'hDD, 8'h01};
    logic [7:0] opts [5] = '{8'h40, 8'h80, 8'hC0, 8'h60, 8'hC1};
    int cls [5] = '{3, 4, 5, 6, 0};
    int mth [5] = '{1, 2, 3, 1, 3};
    int k0;
    for (int i = 0; i < 5; i++) begin
      k0 = n_ok;
      host.send_frame(8'h11, 8'h05, 64'h1, eps[i], 16'h0011, 16'h0000, 8'h00, opts[i], 1, 0);
      wait_done(k0, n_bad);
      chk("ep_class", cls[i], ep_class_o);
      chk("forward", 0, forward_host_o);
      chk("method", mth[i], method_o);
    end
  endtask

  task automatic t_bad;
    int k0, b0;
    k0 = n_ok;
    b0 = n_bad;
    host.offer(8'h55);
    host.send_frame(8'h11, 8'h09, 64'h1, 8'hE8, 16'h0033, 16'hC105, 8'h00, 8'hC0, 2, 8'h01);
    wait_done(k0, b0);
    chk("bad_cksum", b0 + 1, n_bad);
    host.send_frame(8'h10, 8'h09, 64'h1, 8'hE8, 16'h0033, 16'hC105, 8'h00, 8'hC0, 2, 0);
    wait_done(k0, b0 + 1);
    chk("bad_type", b0 + 2, n_bad);
    host.offer(8'h7E);
    host.offer(8'h00);
    host.offer(8'h01);
    host.offer(8'h11);
    host.offer(8'hEE);
    host.idle();
    wait_done(k0, b0 + 2);
    chk("bad_len", b0 + 3, n_bad);
    chk("ok_count", k0, n_ok);
    chk("cluster", 16'h0011, cluster_o);
  endtask

  task automatic test_done;
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog, far beyond the eleven frames sent
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
  // Reset, then the scenarios
  initial begin
    rst_i = 1'b1;
    hold_sink = 1'b0;
    pl_ready_i = 1'b0;
    max_payload_setting_i = 16'h0010;
    default_hop_limit_i = 8'h07;
    default_tx_options_i = 8'hC0;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    t_unicast_stall();
    t_loopback();
    t_bcast_cap();
    t_endpoints();
    t_bad();
    test_done();
  end
endmodule // tb_eatx_frame_parser
